// >>> rtl/ams_sequencer.sv
// What this block does
// - Decode mode from three mode bits, multiport bit.
// - One-shot converts selected input once, then stops.
// - Single input from channel, extended and group fields.
// - Software trigger starts when conversion-go written one.
// - External falling edge starts, only after go set.
// - Timer completion starts, only after go set.
// - One-shot software trigger clears go when done.
// - Writing go zero aborts one-shot and sweep.
// - Repeat modes run until go written zero.
// - One-shot raises interrupt on completion.
// - Repeat modes without DMA never interrupt.
// - With DMA, interrupt after every conversion.
// - Single sweep without DMA interrupts at sequence end.
// - Without DMA, result goes to channel's register.
// - With DMA, results go to register zero only.
// - Sweeps cover 2, 4, 6 or 8 channels.
// - Single sweep software trigger clears go at end.
// - Repeat sweep 0 wraps to first channel forever.
// - Repeat mode reconverts same input back to back.
// - Conversion lasts 49, 59, 28 or 33 cycles.
// - Ten-bit result in bits 9-0, eight in 7-0.
`include "ams_regs.svh"

module ams_sequencer (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic mode_sel_hi_in,
	input wire logic mode_sel_lo_in,
	input wire logic mode_sel_ext_in,
	input wire logic multiport_sel_in,
	input wire logic dma_use_in,
	input wire logic trigger_source_sel_in,
	input wire logic hw_trigger_sel_in,
	input wire logic conv_go_set_in,
	input wire logic conv_go_clr_in,
	output logic conv_go_out,
	input wire logic [2:0] channel_sel_in,
	input wire logic [1:0] ext_input_sel_in,
	input wire logic [1:0] input_group_sel_in,
	input wire logic [1:0] sweep_len_sel_in,
	input wire logic resolution_10b_in,
	input wire logic sample_hold_en_in,
	input wire logic ext_trigger_pin_in,
	input wire logic motor_timer_done_in,
	input wire ams_pkg::ams_word_t adc_raw_in,
	output logic [2:0] ana_chan_out,
	output logic [1:0] ana_group_out,
	output logic [1:0] ana_ext_out,
	output logic ana_sample_out,
	output logic ana_sh_out,
	output logic conv_busy_out,
	output logic conv_irq_out,
	output ams_pkg::ams_word_t result_regs_out [8],
	output logic dma_valid_out,
	input wire logic dma_ready_in,
	output ams_pkg::ams_word_t dma_data_out
);
	import ams_pkg::*;

	// ======================================================================
	// Mode decoding
	// Maps the mode bits onto one mode; unused patterns fall to invalid.
	function automatic ams_mode_t decode_mode(input logic hi, input logic lo,
		input logic ext, input logic multiport_sel);
		logic [3:0] key;
		key = {multiport_sel, hi, lo, ext};
		case (key)
			4'h0: decode_mode = MODE_ONESHOT;
			4'h2: decode_mode = MODE_REPEAT;
			4'h4: decode_mode = MODE_SSWEEP;
			4'h6: decode_mode = MODE_RSWEEP0;
			4'h7: decode_mode = MODE_RSWEEP1;
			4'hc: decode_mode = MODE_MP_SINGLE;
			4'he: decode_mode = MODE_MP_REPEAT;
			default: decode_mode = MODE_INVALID;
		endcase
	endfunction

	ams_mode_t mode; // Current decoded mode.
	logic is_one; // One-shot.
	logic is_rep; // Repeat on one input.
	logic is_ss; // Single sweep family.
	logic is_rs; // Repeat sweep family.
	logic is_sweep; // Any sweep.

	assign mode = decode_mode(mode_sel_hi_in, mode_sel_lo_in, mode_sel_ext_in,
		multiport_sel_in);
	assign is_one = (mode == MODE_ONESHOT);
	assign is_rep = (mode == MODE_REPEAT);
	// The modes without full behaviour here run as their nearest sweep.
	assign is_ss = (mode == MODE_SSWEEP) | (mode == MODE_MP_SINGLE);
	assign is_rs = (mode == MODE_RSWEEP0) | (mode == MODE_RSWEEP1) |
		(mode == MODE_MP_REPEAT);
	assign is_sweep = is_ss | is_rs;

	// ======================================================================
	// External trigger pin synchroniser
	// Three stages: two for metastability, the third only for the edge.
	logic ext_s1_q;
	logic ext_s2_q;
	logic ext_s3_q;
	logic ext_fall; // Falling edge seen on the synchronised pin.

	// The pin rests high, so the stages reset to the idle level.
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ext_s1_q <= `AMS_PIN_IDLE;
			ext_s2_q <= `AMS_PIN_IDLE;
			ext_s3_q <= `AMS_PIN_IDLE;
		end else begin
			ext_s1_q <= ext_trigger_pin_in;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
		end
	end
	assign ext_fall = ext_s3_q & ~ext_s2_q;

	// ======================================================================
	// Sequencer state and its wires
	ams_state_t state_q;
	ams_state_t state_d;
	logic [5:0] cnt_q; // Cycles left in the running conversion.
	logic [5:0] cnt_d;
	logic [2:0] chan_q; // Channel being converted.
	logic [2:0] chan_d;
	logic conv_go_q; // Conversion-go bit.
	logic irq_q; // Interrupt request pulse.
	logic sample_q; // Sample strobe to the analog core.
	logic [1:0] grp_q; // Latched input group.
	logic [1:0] ext_q; // Latched extended-input select.
	logic sh_q; // Latched sample-and-hold choice.
	logic start_evt; // A start condition this cycle.
	logic hw_evt; // A hardware trigger event this cycle.
	logic abort; // Software wrote 0 to the go bit.
	logic load; // Begin a conversion this cycle.
	logic buf_ready; // Buffer can take a word.
	logic store_fire; // Result is stored this cycle.
	logic last_chan; // Current channel ends the sweep group.
	logic seq_end; // Sequence finishes with this store.
	logic irq_cond; // This store raises the interrupt.
	logic go_hw_clr; // Hardware clears the go bit.
	logic [2:0] first_chan; // Channel that opens a sequence.
	logic [2:0] next_chan; // Channel after the current one.
	logic [5:0] tconv; // Length of the next conversion.
	logic [2:0] wr_idx; // Result register written by this store.
	ams_word_t res_word; // Result aligned for the chosen resolution.

	// A hardware trigger only counts while the go bit is already set.
	assign hw_evt = conv_go_q & (hw_trigger_sel_in ? motor_timer_done_in
		: ext_fall);
	assign start_evt = trigger_source_sel_in ? hw_evt : conv_go_set_in;
	// A set and a clear together count as a set.
	assign abort = conv_go_clr_in & ~conv_go_set_in;
	// Without DMA the buffer is not involved and never stalls the store.
	assign store_fire = (state_q == ST_STORE) & (~dma_use_in | buf_ready);
	// Group end is the odd channel 1, 3, 5 or 7 for 2, 4, 6 or 8 channels.
	assign last_chan = is_sweep & (chan_q == {sweep_len_sel_in, 1'h1});
	assign seq_end = is_one | (is_ss & last_chan);
	// Repeat without DMA matches no term and so never interrupts.
	assign irq_cond = is_one | (dma_use_in & ~is_one) |
		(is_ss & last_chan);
	// Hardware triggers leave the go bit up so the next event restarts.
	assign go_hw_clr = store_fire & seq_end & ~trigger_source_sel_in;
	assign first_chan = is_sweep ? `AMS_FIRST_CH : channel_sel_in;
	assign next_chan = is_sweep ? (last_chan ? `AMS_FIRST_CH
		: chan_q + 3'h1) : chan_q;
	assign tconv = resolution_10b_in ?
		(sample_hold_en_in ? `AMS_CYC_10B_SH : `AMS_CYC_10B) :
		(sample_hold_en_in ? `AMS_CYC_8B_SH : `AMS_CYC_8B);
	assign wr_idx = dma_use_in ? `AMS_DMA_IDX : chan_q;
	assign res_word = resolution_10b_in ? adc_raw_in
		: {2'h0, adc_raw_in[9:2]};

	// Next state: a trigger restarts the sequence, an abort beats all.
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		chan_d = chan_q;
		load = 1'h0;
		case (state_q)
			ST_IDLE: begin
				state_d = ST_IDLE;
			end
			ST_CONV: begin
				// The count started at length minus one, so this is exact.
				if (cnt_q == 6'h00) begin
					state_d = ST_STORE;
				end else begin
					cnt_d = cnt_q - 6'h01;
				end
			end
			ST_STORE: begin
				// A full buffer holds the sequencer here, losing no word.
				if (store_fire) begin
					if (seq_end) begin
						state_d = ST_IDLE;
					end else begin
						load = 1'h1;
						chan_d = next_chan;
					end
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		if (start_evt) begin
			load = 1'h1;
			chan_d = first_chan;
		end
		if (load) begin
			state_d = ST_CONV;
			cnt_d = tconv - 6'h01;
		end
		if (abort) begin
			state_d = ST_IDLE;
		end
	end

	// State, counter and channel registers.
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_q <= ST_IDLE;
			cnt_q <= 6'h00;
			chan_q <= 3'h0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			chan_q <= chan_d;
		end
	end

	// Go bit: a software set wins over any clear in the same cycle.
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			conv_go_q <= 1'h0;
		end else if (conv_go_set_in) begin
			conv_go_q <= 1'h1;
		end else if (conv_go_clr_in | go_hw_clr) begin
			conv_go_q <= 1'h0;
		end
	end

	// Interrupt pulse and analog-side controls, latched at each start.
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			irq_q <= 1'h0;
			sample_q <= 1'h0;
			grp_q <= 2'h0;
			ext_q <= 2'h0;
			sh_q <= 1'h0;
		end else begin
			irq_q <= store_fire & irq_cond;
			sample_q <= load & ~abort;
			if (load) begin
				grp_q <= input_group_sel_in;
				// Extended inputs only exist for the single-input modes.
				ext_q <= is_sweep ? 2'h0 : ext_input_sel_in;
				sh_q <= sample_hold_en_in;
			end
		end
	end

	// ======================================================================
	// Result registers
	// One register per channel; each takes a word only when addressed.
	for (genvar g = 0; g < `AMS_NUM_RES; g++) begin : g_res
		always_ff @(posedge sys_clk_in or posedge rst_in) begin
			if (rst_in) begin
				result_regs_out[g] <= 10'h000;
			end else if (store_fire && (wr_idx == 3'(g))) begin
				result_regs_out[g] <= res_word;
			end
		end
	end

	// The DMA side drains the buffer; its stall reaches the store above.
	ams_buf2 u_buf (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.in_valid_in(store_fire & dma_use_in),
		.in_ready_out(buf_ready),
		.in_data_in(res_word),
		.out_valid_out(dma_valid_out),
		.out_ready_in(dma_ready_in),
		.out_data_out(dma_data_out)
	);

	// Port drive.
	assign conv_go_out = conv_go_q;
	assign conv_irq_out = irq_q;
	assign ana_chan_out = chan_q;
	assign ana_group_out = grp_q;
	assign ana_ext_out = ext_q;
	assign ana_sample_out = sample_q;
	assign ana_sh_out = sh_q;
	assign conv_busy_out = (state_q != ST_IDLE);

	// ======================================================================
	// Assertions
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (rst_in);

	AST_DECODE_ONESHOT:
	assert property ((!multiport_sel_in && !mode_sel_hi_in && !mode_sel_lo_in
		&& !mode_sel_ext_in) |-> is_one) else $error("one-shot not decoded");
	AST_ONESHOT_STOP:
	assert property (store_fire && is_one && !start_evt |=> state_q == ST_IDLE)
		else $error("one-shot did not stop");
	AST_SW_START:
	assert property (conv_go_set_in && !trigger_source_sel_in |=> ##[0:0]
		(state_q == ST_CONV && cnt_q == $past(tconv) - 6'h01))
		else $error("software start missed");
	AST_EXT_START:
	assert property (conv_go_q && trigger_source_sel_in && !hw_trigger_sel_in
		&& $fell(ext_s2_q) && !conv_go_clr_in |=> state_q == ST_CONV)
		else $error("external edge missed");
	AST_TIMER_IGNORED:
	assert property (!conv_go_q && !conv_go_set_in && trigger_source_sel_in
		&& state_q == ST_IDLE |=> state_q == ST_IDLE)
		else $error("trigger taken before go");
	AST_GO_AUTOCLR:
	assert property (store_fire && seq_end && !trigger_source_sel_in
		&& !conv_go_set_in |=> !conv_go_q) else $error("go not cleared");
	AST_ABORT:
	assert property (abort |=> state_q == ST_IDLE && !conv_busy_out)
		else $error("abort ignored");
	AST_REPEAT_NO_IRQ:
	assert property (store_fire && is_rep && !dma_use_in |=> !conv_irq_out)
		else $error("repeat raised interrupt");
	AST_DMA_IRQ:
	assert property (store_fire && dma_use_in |=> conv_irq_out)
		else $error("dma interrupt missing");
	AST_RES_INDEX:
	assert property (store_fire && !dma_use_in |=>
		result_regs_out[$past(chan_q)] == $past(res_word))
		else $error("result in wrong register");
	AST_DMA_ZERO:
	assert property (store_fire && dma_use_in |=> result_regs_out[0] == $past(res_word)
		&& dma_valid_out) else $error("dma word not in register zero");
	AST_SWEEP_STEP:
	assert property (store_fire && is_sweep && !last_chan && !start_evt && !abort
		|=> chan_q == $past(chan_q) + 3'h1 && state_q == ST_CONV)
		else $error("sweep order broken");
	AST_RS_WRAP:
	assert property (store_fire && is_rs && last_chan && !start_evt && !abort
		|=> chan_q == 3'h0 && state_q == ST_CONV)
		else $error("repeat sweep did not wrap");
	AST_CONV_LEN:
	assert property (state_q == ST_CONV && cnt_q == 6'h00 && !start_evt && !abort
		|=> state_q == ST_STORE) else $error("conversion length wrong");

	COV_ONESHOT: cover property (store_fire && is_one);
	COV_SWEEP_WRAP: cover property (store_fire && is_rs && last_chan);
	COV_DMA_STALL: cover property (state_q == ST_STORE && dma_use_in && !buf_ready);
	COV_EXT_START: cover property (hw_evt && !hw_trigger_sel_in);
endmodule

// >>> rtl/ams_regs.svh
`ifndef AMS_REGS_SVH
`define AMS_REGS_SVH
// ==========================================================================
// Timing and field constants of the converter sequencer.
// Clock period in nanoseconds; the converter clock is the system clock.
`define AMS_CLK_PERIOD_NS 100
// Conversion lengths in converter clock cycles.
`define AMS_CYC_8B 6'd49
`define AMS_CYC_10B 6'd59
`define AMS_CYC_8B_SH 6'd28
`define AMS_CYC_10B_SH 6'd33
// Width of one result word and number of result registers.
`define AMS_RES_W 10
`define AMS_NUM_RES 8
// Result register that receives every word in DMA use.
`define AMS_DMA_IDX 3'h0
// First channel of a sweep group.
`define AMS_FIRST_CH 3'h0
// Reset level of the external trigger pin (idle high, active falling edge).
`define AMS_PIN_IDLE 1'h1
`endif

// >>> rtl/ams_pkg.sv
// ==========================================================================
// Types shared by the sequencer and its result buffer.
package ams_pkg;
	// One result word.
	typedef logic [9:0] ams_word_t;
	// Decoded operating mode.
	typedef enum logic [2:0] {
		MODE_ONESHOT = 3'b000,
		MODE_REPEAT = 3'b001,
		MODE_SSWEEP = 3'b010,
		MODE_RSWEEP0 = 3'b011,
		MODE_RSWEEP1 = 3'b100,
		MODE_MP_SINGLE = 3'b101,
		MODE_MP_REPEAT = 3'b110,
		MODE_INVALID = 3'b111
	} ams_mode_t;
	// Sequencer state.
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CONV = 2'b01,
		ST_STORE = 2'b10
	} ams_state_t;
endpackage

// >>> rtl/ams_buf2.sv
// ==========================================================================
// Two-entry buffer between the result path and the DMA request side.
module ams_buf2 (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire ams_pkg::ams_word_t in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output ams_pkg::ams_word_t out_data_out
);
	import ams_pkg::*;

	// Storage, pointers and fill level.
	ams_word_t mem_q [2];
	logic wr_ptr_q;
	logic rd_ptr_q;
	logic [1:0] count_q;
	logic push;
	logic pop;

	// Full and empty come straight from the fill level, so they never lie.
	assign in_ready_out = (count_q != 2'h2);
	assign out_valid_out = (count_q != 2'h0);
	assign push = in_valid_in & in_ready_out;
	assign pop = out_valid_out & out_ready_in;
	// The read side looks only at flip-flops.
	assign out_data_out = mem_q[rd_ptr_q];

	// Pointer and fill bookkeeping.
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			wr_ptr_q <= 1'h0;
			rd_ptr_q <= 1'h0;
			count_q <= 2'h0;
		end else begin
			if (push) wr_ptr_q <= ~wr_ptr_q;
			if (pop) rd_ptr_q <= ~rd_ptr_q;
			count_q <= count_q + {1'h0, push} - {1'h0, pop};
		end
	end

	// Word storage; written only on an accepted push.
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			mem_q[0] <= 10'h000;
			mem_q[1] <= 10'h000;
		end else if (push) begin
			mem_q[wr_ptr_q] <= in_data_in;
		end
	end
endmodule

// >>> tb/ams_far_side.sv
// ==========
// Far side of the sequencer: the analog core and the DMA controller.
module ams_far_side (
	input wire logic sys_clk_in,
	input wire logic [2:0] ana_chan_in,
	input wire logic [1:0] ana_group_in,
	input wire logic [1:0] ana_ext_in,
	input wire logic stall_in,
	input wire logic slow_in,
	output ams_pkg::ams_word_t adc_raw_out,
	output logic dma_ready_out
);
	timeunit 1ns;
	timeprecision 1ns;
	import ams_pkg::*;
	// Pacing counter; a slow DMA takes one word in four cycles.
	logic [1:0] pace_q = 2'h0;
	// Every input yields its own code, so a wrong pick shows in the result.
	assign adc_raw_out = {ana_group_in, ana_chan_in, ana_ext_in, 3'h5};
	// The DMA moves words out of the result path, and may stall or dawdle.
	always_ff @(posedge sys_clk_in) begin
		pace_q <= pace_q + 2'h1;
	end
	assign dma_ready_out = !stall_in && (!slow_in || pace_q == 2'h0);
endmodule

// >>> tb/tb_top.sv
// ==========
// Self-checking bench for the converter sequencer.
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import ams_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic hi, lo, ext, multiport_sel, dma, trigger_source_sel, hws, set, clr, res10, sh, pin, tmr, stall, slow;
	logic [2:0] ch;
	logic [1:0] xs, grp, len;
	logic go, busy, irq, dv, dr, samp, shq;
	logic [2:0] achan;
	logic [1:0] agrp, aext;
	ams_word_t raw, dd;
	ams_word_t res [8];
	ams_word_t exp_reg [8];
	// Expected DMA words, oldest first.
	ams_word_t q [$];
	int failures = 0;
	int n_compared = 0;
	int n_irq, n_pop, n_busy, n_samp;
	int cyc = 0;
	integer seed = 32'h547f;
	always #50 clk = ~clk;
	ams_sequencer DUT (.sys_clk_in(clk), .rst_in(rst), .mode_sel_hi_in(hi),
		.mode_sel_lo_in(lo), .mode_sel_ext_in(ext), .multiport_sel_in(multiport_sel),
		.dma_use_in(dma), .trigger_source_sel_in(trigger_source_sel), .hw_trigger_sel_in(hws),
		.conv_go_set_in(set), .conv_go_clr_in(clr), .conv_go_out(go),
		.channel_sel_in(ch), .ext_input_sel_in(xs), .input_group_sel_in(grp),
		.sweep_len_sel_in(len), .resolution_10b_in(res10), .sample_hold_en_in(sh),
		.ext_trigger_pin_in(pin), .motor_timer_done_in(tmr), .adc_raw_in(raw),
		.ana_chan_out(achan), .ana_group_out(agrp), .ana_ext_out(aext),
		.ana_sample_out(samp), .ana_sh_out(shq), .conv_busy_out(busy),
		.conv_irq_out(irq), .result_regs_out(res), .dma_valid_out(dv),
		.dma_ready_in(dr), .dma_data_out(dd));
	ams_far_side FAR (.sys_clk_in(clk), .ana_chan_in(achan), .ana_group_in(agrp),
		.ana_ext_in(aext), .stall_in(stall), .slow_in(slow), .adc_raw_out(raw),
		.dma_ready_out(dr));
	// ==========
	// Helpers. Inputs always move 1 ns after the rising edge.
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Our own picture of a stored word; 8-bit results drop the two low bits.
	// Single-input modes carry the extended select; sweeps leave it at zero.
	function automatic ams_word_t code(input logic [1:0] g, input logic [2:0] c);
		code = {g, c, hi ? 2'h0 : xs, 3'h5};
		if (!res10)
			code = {2'h0, code[9:2]};
	endfunction
	task automatic mode(input logic h, input logic l, input logic d);
		{hi, lo, dma} = {h, l, d};
		n_irq = 0;
		n_pop = 0;
		n_busy = 0;
		n_samp = 0;
	endtask
	// The go pulse stands for one software write; busy shows one edge later.
	task automatic pulse(input bit on);
		if (on)
			set = 1'b1;
		else
			clr = 1'b1;
		tick(1);
		{set, clr} = 2'h0;
		tick(2);
	endtask
	// Bounded wait for the sequencer to fall idle; a hang counts as a mismatch.
	task automatic wait_idle;
		int k;
		k = 0;
		while (busy !== 1'b0 && k < 600) begin
			tick(1);
			k++;
		end
		if (k == 600)
			failures++;
		tick(2);
	endtask
	task automatic summarize;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ==========
	// Watcher: counts pulses and compares each DMA word with the oldest note.
	always @(posedge clk) begin
		cyc++;
		if (irq === 1'b1)
			n_irq++;
		if (busy === 1'b1)
			n_busy++;
		if (samp === 1'b1)
			n_samp++;
		if (dv === 1'b1 && dr === 1'b1) begin
			n_pop++;
			if (q.size() == 0)
				check(dd, 16'hffff);
			else
				check(dd, q.pop_front());
		end
		if (cyc == 40000) begin
			failures++;
			summarize();
		end
	end
	// ==========
	// Main sequence.
	initial begin
		{hi, lo, ext, multiport_sel, dma, trigger_source_sel, hws, set, clr, sh, tmr, stall, slow} = 13'h0;
		{ch, xs, grp, len} = 9'h0;
		res10 = 1'b1;
		pin = 1'b1;
		tick(2);
		rst = 1'b0;
		tick(1);
		// One-shot on every channel, all four timing settings.
		for (int i = 0; i < 8; i++) begin
			mode(1'b0, 1'b0, 1'b0);
			ch = 3'(i);
			grp = 2'($random(seed));
			xs = 2'($random(seed));
			{sh, res10} = 2'(i);
			pulse(1'b1);
			wait_idle();
			exp_reg[i] = code(grp, ch);
			check(res[i], exp_reg[i]);
			check(go, 0);
			check(n_irq, 1);
			check(n_busy, res10 ? (sh ? 34 : 60) : (sh ? 29 : 50));
			check(shq, sh);
			check(aext, xs);
		end
		$display("test one_shot done");
		// Single sweep over every length, ascending from channel 0.
		{res10, sh} = 2'h3;
		for (int l = 0; l < 4; l++) begin
			mode(1'b1, 1'b0, 1'b0);
			len = 2'(l);
			grp = 2'($random(seed));
			pulse(1'b1);
			wait_idle();
			for (int k = 0; k < 2 * l + 2; k++) begin
				exp_reg[k] = code(grp, 3'(k));
				check(res[k], exp_reg[k]);
			end
			check(n_irq, 1);
			check(go, 0);
		end
		$display("test sweep done");
		// Repeat mode without DMA runs until cleared and stays silent.
		mode(1'b0, 1'b1, 1'b0);
		ch = 3'h5;
		pulse(1'b1);
		tick(300);
		check(n_irq, 0);
		check(go, 1);
		check(n_samp > 5, 1);
		exp_reg[5] = code(grp, ch);
		check(res[5], exp_reg[5]);
		pulse(1'b0);
		wait_idle();
		check(go, 0);
		$display("test repeat done");
		// Repeat sweep 0 with DMA, stalled then slow; no word may be lost.
		mode(1'b1, 1'b1, 1'b1);
		len = 2'h0;
		grp = 2'($random(seed));
		for (int k = 0; k < 16; k++)
			q.push_back(code(grp, 3'(k % 2)));
		stall = 1'b1;
		pulse(1'b1);
		tick(200);
		check(n_irq, 2);
		stall = 1'b0;
		slow = 1'b1;
		for (int k = 0; k < 600 && n_pop < 6; k++)
			tick(1);
		check(n_pop > 5, 1);
		pulse(1'b0);
		wait_idle();
		tick(20);
		check(n_irq, n_pop);
		q.delete();
		slow = 1'b0;
		$display("test dma done");
		// Multiport single sweep: software sets DMA use with it, one word per channel.
		multiport_sel = 1'b1;
		mode(1'b1, 1'b0, 1'b1);
		len = 2'h1;
		for (int k = 0; k < 4; k++)
			q.push_back(code(grp, 3'(k)));
		pulse(1'b1);
		wait_idle();
		check(n_irq, 4);
		check(n_pop, 4);
		check(q.size(), 0);
		check(go, 0);
		multiport_sel = 1'b0;
		$display("test multiport done");
		// Abort a one-shot in mid-conversion; nothing may be stored.
		mode(1'b0, 1'b0, 1'b0);
		ch = 3'h3;
		grp = grp + 2'h1;
		pulse(1'b1);
		tick(10);
		pulse(1'b0);
		check(busy, 0);
		tick(70);
		check(res[3], exp_reg[3]);
		check(n_irq, 0);
		$display("test abort done");
		// Pin edges count only once go is set; go then stays set.
		trigger_source_sel = 1'b1;
		ch = 3'h2;
		pin = 1'b0;
		tick(10);
		pin = 1'b1;
		pulse(1'b1);
		tick(5);
		check(busy, 0);
		pin = 1'b0;
		tick(7);
		check(busy, 1);
		wait_idle();
		check(go, 1);
		check(res[2], code(grp, ch));
		pin = 1'b1;
		hws = 1'b1;
		tmr = 1'b1;
		tick(1);
		tmr = 1'b0;
		tick(2);
		check(busy, 1);
		wait_idle();
		pulse(1'b0);
		tmr = 1'b1;
		tick(1);
		tmr = 1'b0;
		tick(3);
		check(busy, 0);
		$display("test trigger done");
		summarize();
	end
endmodule
